// ===== hdl/dscg_clock_gen.sv
// Purpose: picks the cpu and peripheral clock from the x1 or internal oscillator
// Assumes: x1_clk_in and int_osc_clk_in are far slower than clk_sys (250 MHz)
// Notes: cpu and peripheral clocks leave as one-cycle enables on clk_sys

`timescale 1ns/1ps
`default_nettype none

// How it works
// [R1] any reset clears the cpu clock select bit, internal oscillator drives cpu
// [R2] after reset release cpu enables wait for 17 internal oscillator edges
// [R3] both oscillators are held stopped during reset
// [R4] software checks stabilization status before selecting x1
// [R5] cpu clock status sits at bit 1 of the main clock mode register
// [R6] software stops internal oscillator only while status reads one
// [R7] software stops x1 only while status reads zero
// [R8] x1 stop at bit 7 of its control register, internal stop at bit 0
// [R9] stop release on x1 waits the selected stabilization time
// [R10] reset release and stop release on internal clock insert no stabilization wait
// [R11] prescaler enable follows the x1 or internal edges per cpu source
// [R12] after stop the cpu resumes on the source selected before stop
// [R13] during halt peripherals keep running on the pre-halt cpu clock
// [R14] x1 stop acts only while the internal oscillator runs
// [R15] software never sets both stop bits at once
// [R16] internal stop bit acts only with the stoppable option
// [R17] stoppable option: watchdog halts in halt and stop, oscillator may run
// [R18] non-stoppable option: watchdog counts on internal clock even in stop
// [R19] pin, power-on clear, low voltage and watchdog all enter reset
// [R20] x1 stop while cpu runs on x1 leaves x1 running
// [R21] stabilization status bits set in order from the shortest and stay set
// [R22] stoppable option is a strap latched while reset is held
// [R23] status changes only when the source switch has completed
module dscg_clock_gen #(
    parameter int unsigned START_WAIT = dscg_pkg::START_EDGES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ext_reset_n,
    input wire logic power_on_clear,
    input wire logic low_voltage_detect,
    input wire logic watchdog_reset,
    input wire logic int_osc_stoppable_opt,
    input wire logic x1_clk_in,
    input wire logic int_osc_clk_in,
    input wire logic [7:0] reg_wdata,
    input wire logic main_clock_mode_wr,
    input wire logic x1_osc_control_wr,
    input wire logic int_osc_mode_wr,
    input wire logic stab_time_select_wr,
    input wire logic halt_req,
    input wire logic stop_req,
    input wire logic wake,
    output logic [7:0] main_clock_mode_reg,
    output logic [7:0] x1_osc_control_reg,
    output logic [7:0] int_osc_mode_reg,
    output logic [7:0] stab_count_status_reg,
    output logic [7:0] stab_time_select_reg,
    output logic x1_osc_enable,
    output logic int_osc_enable,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic watchdog_run,
    output logic watchdog_clk_en,
    output logic in_reset
);

    typedef struct packed {
        dscg_pkg::dscg_mode_t st;
        logic [4:0] start_cnt;
        logic [dscg_pkg::STAB_CNT_W-1:0] stab_cnt;
        logic [dscg_pkg::STAB_BITS-1:0] stab_st;
        logic cap_sel;
        logic stoppable;
        logic sel;
        logic status;
        logic x1_stop;
        logic int_stop;
        logic [dscg_pkg::STAB_SEL_W-1:0] stab_sel;
        logic x1_run;
        logic int_run;
        logic cpu_en;
        logic per_en;
        logic wdt_run;
        logic wdt_en;
        logic x1_s1;
        logic x1_s2;
        logic x1_s3;
        logic ir_s1;
        logic ir_s2;
        logic ir_s3;
        logic rs_s1;
        logic rs_s2;
        logic rst_st;
    } dscg_state_t;

    dscg_state_t q;
    dscg_state_t d;

    // stabilization threshold for a select code, in x1 edges
    function automatic logic [dscg_pkg::STAB_CNT_W-1:0] dscg_thresh(
        input logic [dscg_pkg::STAB_SEL_W-1:0] code
    );
        int unsigned e;
        e = dscg_pkg::EXP_16;
        case (code)
            dscg_pkg::STAB_SEL_11: e = dscg_pkg::EXP_11;
            dscg_pkg::STAB_SEL_13: e = dscg_pkg::EXP_13;
            dscg_pkg::STAB_SEL_14: e = dscg_pkg::EXP_14;
            dscg_pkg::STAB_SEL_15: e = dscg_pkg::EXP_15;
            default: e = dscg_pkg::EXP_16;
        endcase
        return dscg_pkg::STAB_CNT_W'(1) << e;
    endfunction : dscg_thresh

    // thresholds of the status bits, first entry (for status bit 4) is the shortest time
    logic [dscg_pkg::STAB_BITS-1:0][dscg_pkg::STAB_CNT_W-1:0] stab_lim;
    genvar gi;
    generate
        for (gi = 0; gi < dscg_pkg::STAB_BITS; gi++) begin : g_lim
            assign stab_lim[gi] = dscg_thresh(3'(gi + 1));
        end
    endgenerate

    logic any_rst;
    logic x1_edge;
    logic ir_edge;
    logic src_edge;
    logic [dscg_pkg::STAB_CNT_W-1:0] cap;
    logic stab_done;
    logic int_stop_eff;
    logic x1_stop_eff;

    // next-state logic for the whole generator
    always_comb begin
        d = q;
        // pin synchronisers; the first stage feeds only the second
        d.x1_s1 = x1_clk_in;
        d.x1_s2 = q.x1_s1;
        d.x1_s3 = q.x1_s2;
        d.ir_s1 = int_osc_clk_in;
        d.ir_s2 = q.ir_s1;
        d.ir_s3 = q.ir_s2;
        d.rs_s1 = ext_reset_n;
        d.rs_s2 = q.rs_s1;

        any_rst = !q.rs_s2 || power_on_clear || low_voltage_detect || watchdog_reset; // R19
        x1_edge = q.x1_s2 && !q.x1_s3 && q.x1_run;
        ir_edge = q.ir_s2 && !q.ir_s3 && q.int_run;
        src_edge = q.status ? x1_edge : ir_edge; // R11
        cap = q.cap_sel ? dscg_thresh(q.stab_sel) : stab_lim[dscg_pkg::STAB_BITS-1];
        stab_done = (q.stab_cnt >= dscg_thresh(q.stab_sel));

        d.cpu_en = 1'b0;
        d.per_en = 1'b0;
        d.wdt_en = 1'b0;

        // software writes, taken outside reset only
        if (q.st != dscg_pkg::DSCG_RESET) begin
            if (main_clock_mode_wr) begin
                d.sel = reg_wdata[dscg_pkg::SEL_BIT];
            end
            if (x1_osc_control_wr) begin
                d.x1_stop = reg_wdata[dscg_pkg::X1_STOP_BIT];
            end
            if (int_osc_mode_wr) begin
                d.int_stop = reg_wdata[dscg_pkg::INT_STOP_BIT];
            end
            if (stab_time_select_wr) begin
                d.stab_sel = reg_wdata[dscg_pkg::STAB_SEL_W-1:0];
            end
        end

        // oscillator run controls
        int_stop_eff = q.stoppable && q.int_stop && q.status && !q.x1_stop; // R16 R15
        x1_stop_eff = q.x1_stop && !q.status && q.int_run; // R14 R20
        d.int_run = !int_stop_eff; // R17 R18
        d.x1_run = !x1_stop_eff && (q.st != dscg_pkg::DSCG_STOP);

        // stabilization counter restarts whenever x1 is not running
        if (!q.x1_run) begin
            d.stab_cnt = '0;
            d.stab_st = '0;
        end else if (x1_edge && (q.stab_cnt < cap)) begin
            d.stab_cnt = q.stab_cnt + 1'b1;
        end
        // status bits set in order and stay set until x1 stops
        for (int i = 0; i < dscg_pkg::STAB_BITS; i++) begin
            if (q.x1_run && (q.stab_cnt >= stab_lim[i])) begin
                d.stab_st[dscg_pkg::STAB_BITS-1-i] = 1'b1; // R21
            end
        end

        // watchdog runs unless the stoppable option idles it in standby
        d.wdt_run = !(q.stoppable && ((q.st == dscg_pkg::DSCG_HALT)
            || (q.st == dscg_pkg::DSCG_STOP) || (q.st == dscg_pkg::DSCG_STAB))); // R17 R18
        d.wdt_en = q.wdt_run && ir_edge && (q.st != dscg_pkg::DSCG_RESET); // R18

        case (q.st)
            dscg_pkg::DSCG_RESET: begin
                d.stoppable = int_osc_stoppable_opt; // R22
                d.start_cnt = '0;
                if (!any_rst) begin
                    d.st = dscg_pkg::DSCG_START; // R10
                end
            end
            dscg_pkg::DSCG_START: begin
                if (ir_edge) begin
                    d.start_cnt = q.start_cnt + 1'b1;
                    if (32'(q.start_cnt) + 1 >= START_WAIT) begin
                        d.st = dscg_pkg::DSCG_RUN; // R2
                    end
                end
            end
            dscg_pkg::DSCG_RUN: begin
                d.cpu_en = src_edge;
                d.per_en = src_edge; // R11
                // status flips on the first edge of the target clock
                if (q.sel && !q.status && x1_edge) begin
                    d.status = 1'b1; // R23
                end else if (!q.sel && q.status && ir_edge) begin
                    d.status = 1'b0; // R23
                end
                if (stop_req) begin
                    d.st = dscg_pkg::DSCG_STOP;
                end else if (halt_req) begin
                    d.st = dscg_pkg::DSCG_HALT;
                end
            end
            dscg_pkg::DSCG_HALT: begin
                d.per_en = src_edge; // R13
                if (wake) begin
                    d.st = dscg_pkg::DSCG_RUN;
                end
            end
            dscg_pkg::DSCG_STOP: begin
                if (wake) begin
                    if (q.status) begin
                        d.st = dscg_pkg::DSCG_STAB; // R9 R12
                        d.cap_sel = 1'b1;
                    end else begin
                        d.st = dscg_pkg::DSCG_RUN; // R10 R12
                    end
                end
            end
            dscg_pkg::DSCG_STAB: begin
                if (q.x1_run && stab_done) begin
                    d.st = dscg_pkg::DSCG_RUN; // R9
                end
            end
            default: begin
                d.st = dscg_pkg::DSCG_RESET;
            end
        endcase

        // a fresh stop counts the full range until the next stop release
        if (q.st == dscg_pkg::DSCG_RUN && q.x1_stop && !q.status) begin
            d.cap_sel = 1'b0;
        end

        // every reset source forces the reset state
        if (any_rst) begin
            d.st = dscg_pkg::DSCG_RESET; // R19
            d.sel = 1'b0; // R1
            d.status = 1'b0; // R1
            d.x1_stop = 1'b0;
            d.int_stop = 1'b0;
            d.stab_sel = dscg_pkg::STAB_SEL_RESET;
            d.cap_sel = 1'b0;
            d.x1_run = 1'b0; // R3
            d.int_run = 1'b0; // R3
            d.cpu_en = 1'b0;
            d.per_en = 1'b0;
            d.wdt_en = 1'b0;
            d.stab_cnt = '0;
            d.stab_st = '0;
        end
        // reset state flag kept in a flop so the output needs no decode
        d.rst_st = (d.st == dscg_pkg::DSCG_RESET);
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: dscg_pkg::DSCG_RESET, stab_sel: dscg_pkg::STAB_SEL_RESET,
                   wdt_run: 1'b1, rst_st: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    // register images and controls straight from the state register
    assign main_clock_mode_reg = {6'h00, q.status, q.sel}; // R5 R8
    assign x1_osc_control_reg = {q.x1_stop, 7'h00}; // R8
    assign int_osc_mode_reg = {7'h00, q.int_stop}; // R8
    assign stab_count_status_reg = {3'h0, q.stab_st};
    assign stab_time_select_reg = {5'h00, q.stab_sel};
    assign x1_osc_enable = q.x1_run;
    assign int_osc_enable = q.int_run;
    assign cpu_clk_en = q.cpu_en;
    assign periph_clk_en = q.per_en;
    assign watchdog_run = q.wdt_run;
    assign watchdog_clk_en = q.wdt_en;
    assign in_reset = q.rst_st;

endmodule : dscg_clock_gen

`default_nettype wire

// ===== inc/dscg_pkg.sv
// Purpose: constants and types shared by the dual source clock generator
// Assumes: oscillator clocks arrive as plain pins and are sampled on clk_sys
// Notes: register images are byte wide; only the bits named here are live

package dscg_pkg;

    // bit positions inside the register images
    localparam int unsigned SEL_BIT = 0;
    localparam int unsigned STATUS_BIT = 1;
    localparam int unsigned X1_STOP_BIT = 7;
    localparam int unsigned INT_STOP_BIT = 0;
    localparam int unsigned STAB_SEL_W = 3;

    // reset values
    localparam logic [2:0] STAB_SEL_RESET = 3'h5;
    localparam logic [7:0] REG_ZERO = 8'h00;

    // internal oscillator edges that gate the cpu after reset release
    localparam int unsigned START_EDGES = 17;

    // stabilization counter spans 2^16 x1 edges
    localparam int unsigned STAB_CNT_W = 17;
    localparam int unsigned STAB_BITS = 5;

    // stabilization time select codes and their powers of two
    localparam logic [2:0] STAB_SEL_11 = 3'h1;
    localparam logic [2:0] STAB_SEL_13 = 3'h2;
    localparam logic [2:0] STAB_SEL_14 = 3'h3;
    localparam logic [2:0] STAB_SEL_15 = 3'h4;
    localparam logic [2:0] STAB_SEL_16 = 3'h5;
    localparam int unsigned EXP_11 = 11;
    localparam int unsigned EXP_13 = 13;
    localparam int unsigned EXP_14 = 14;
    localparam int unsigned EXP_15 = 15;
    localparam int unsigned EXP_16 = 16;

    // operating states of the generator
    typedef enum logic [2:0] {
        DSCG_RESET,
        DSCG_START,
        DSCG_RUN,
        DSCG_HALT,
        DSCG_STOP,
        DSCG_STAB
    } dscg_mode_t;

endpackage : dscg_pkg

// ===== test/dscg_clock_gen_assertions.sv
// Purpose: concurrent checks on the clock generator ports
// Assumes: one clock domain, rst_n asynchronous active low
// Notes: bound into every dscg_clock_gen instance
`timescale 1ns/1ps
`default_nettype none
module dscg_clock_gen_assertions (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic int_osc_stoppable_opt,
    input wire logic x1_osc_control_wr,
    input wire logic halt_req,
    input wire logic stop_req,
    input wire logic [7:0] main_clock_mode_reg,
    input wire logic [7:0] stab_count_status_reg,
    input wire logic x1_osc_enable,
    input wire logic int_osc_enable,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic watchdog_clk_en,
    input wire logic in_reset
);
    // all checks sample on the system clock and sleep while rst_n is low
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_sel_clear; in_reset [*2] |-> !main_clock_mode_reg[0]; endproperty
    a_sel_clear: assert property (p_sel_clear) else $error("select set in reset");
    property p_osc_off; in_reset [*2] |-> !x1_osc_enable && !int_osc_enable; endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator on in reset");
    property p_cpu_held; in_reset [*2] |-> !cpu_clk_en && !periph_clk_en; endproperty
    a_cpu_held: assert property (p_cpu_held) else $error("clock pulse in reset");
    property p_start_gap; $fell(in_reset) |-> !cpu_clk_en [*8]; endproperty
    a_start_gap: assert property (p_start_gap) else $error("cpu clock too early");
    // status may only move towards the select bit, never ahead of it
    property p_status_follow; !in_reset && $changed(main_clock_mode_reg[1])
        |-> main_clock_mode_reg[1] == $past(main_clock_mode_reg[0]); endproperty
    a_status_follow: assert property (p_status_follow) else $error("status moved alone");
    property p_sel_late; $rose(main_clock_mode_reg[0]) |-> !main_clock_mode_reg[1]; endproperty
    a_sel_late: assert property (p_sel_late) else $error("status set with select");
    property p_x1_keep; !in_reset && x1_osc_enable && main_clock_mode_reg[1]
        && x1_osc_control_wr && !stop_req |=> x1_osc_enable [*2]; endproperty
    a_x1_keep: assert property (p_x1_keep) else $error("x1 stopped under cpu");
    property p_int_always; (!in_reset && !int_osc_stoppable_opt) [*3] |-> int_osc_enable;
    endproperty
    a_int_always: assert property (p_int_always) else $error("fixed oscillator off");
    property p_halt_quiet; halt_req && !in_reset |-> ##2
        (!cpu_clk_en && !(int_osc_stoppable_opt && watchdog_clk_en)) [*6]; endproperty
    a_halt_quiet: assert property (p_halt_quiet) else $error("clock pulse in halt");
    property p_stop_quiet; stop_req && !in_reset |-> ##2
        (!cpu_clk_en && !periph_clk_en) [*8]; endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("clock pulse in stop");
    property p_stab_order; stab_count_status_reg inside
        {8'h00, 8'h10, 8'h18, 8'h1c, 8'h1e, 8'h1f}; endproperty
    a_stab_order: assert property (p_stab_order) else $error("status bits out of order");
endmodule : dscg_clock_gen_assertions
bind dscg_clock_gen dscg_clock_gen_assertions u_dscg_clock_gen_assertions (.clk_sys, .rst_n,
    .int_osc_stoppable_opt, .x1_osc_control_wr, .halt_req, .stop_req, .main_clock_mode_reg,
    .stab_count_status_reg, .x1_osc_enable, .int_osc_enable, .cpu_clk_en, .periph_clk_en,
    .watchdog_clk_en, .in_reset);
`default_nettype wire

// ===== test/dscg_osc_model.sv
// Purpose: oscillator sources feeding the clock generator pins
// Assumes: a disabled oscillator stands low until enabled again
// Notes: half periods are parameters so fast and slow parts can be tried
`timescale 1ns/1ps
`default_nettype none
module dscg_osc_model #(
    parameter int X1_HALF = 12,
    parameter int INT_HALF = 40
) (
    input wire logic x1_osc_enable,
    input wire logic int_osc_enable,
    output logic x1_clk_in,
    output logic int_osc_clk_in
);
    // each oscillator toggles only while enabled, otherwise it stands still
    initial x1_clk_in = 1'h0;
    initial int_osc_clk_in = 1'h0;
    always #(X1_HALF) x1_clk_in = x1_osc_enable ? ~x1_clk_in : 1'h0;
    always #(INT_HALF) int_osc_clk_in = int_osc_enable ? ~int_osc_clk_in : 1'h0;
endmodule : dscg_osc_model
`default_nettype wire

// ===== test/testbench.sv
// Purpose: self-checking bench for the dual source clock generator
// Assumes: x1 period 6 and internal period 20 system clocks
// Notes: inputs change on the falling edge; waits are bounded
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys, rst_n, ext_reset_n, power_on_clear, low_voltage_detect, watchdog_reset;
    logic int_osc_stoppable_opt, x1_clk_in, int_osc_clk_in, halt_req, stop_req, wake;
    logic main_clock_mode_wr, x1_osc_control_wr, int_osc_mode_wr, stab_time_select_wr;
    logic [7:0] reg_wdata, main_clock_mode_reg, x1_osc_control_reg, int_osc_mode_reg;
    logic [7:0] stab_count_status_reg, stab_time_select_reg, rnd;
    logic x1_osc_enable, int_osc_enable, cpu_clk_en, periph_clk_en, watchdog_run;
    logic watchdog_clk_en, in_reset;
    int fails, samples_checked, n, k, m, ie;
    dscg_clock_gen u_dscg_clock_gen (.clk_sys, .rst_n, .ext_reset_n, .power_on_clear,
        .low_voltage_detect, .watchdog_reset, .int_osc_stoppable_opt, .x1_clk_in,
        .int_osc_clk_in, .reg_wdata, .main_clock_mode_wr, .x1_osc_control_wr,
        .int_osc_mode_wr, .stab_time_select_wr, .halt_req, .stop_req, .wake,
        .main_clock_mode_reg, .x1_osc_control_reg, .int_osc_mode_reg, .stab_count_status_reg,
        .stab_time_select_reg, .x1_osc_enable, .int_osc_enable, .cpu_clk_en, .periph_clk_en,
        .watchdog_run, .watchdog_clk_en, .in_reset);
    dscg_osc_model u_dscg_osc_model (.x1_osc_enable, .int_osc_enable, .x1_clk_in,
        .int_osc_clk_in);
    // system clock, 4 ns period, offset so oscillator edges never share its time steps
    initial begin
        clk_sys = 1'h0;
        #1;
        forever #2 clk_sys = ~clk_sys;
    end
    // raw internal oscillator edges, cleared by the main sequence
    always @(posedge int_osc_clk_in) ie++;
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    function automatic logic sig(input int w);
        case (w)
            0: return cpu_clk_en;
            1: return main_clock_mode_reg[1];
            2: return stab_count_status_reg[4];
            4: return x1_clk_in;
            default: return in_reset;
        endcase
    endfunction : sig
    task automatic complete_run();
        $display("checked %0d, bad %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) @(negedge clk_sys);
    endtask : tick
    // waits for a watched output to reach v, n holds the cycles spent
    task automatic await(input int w, input logic v, input int lim);
        n = 0;
        while (sig(w) !== v) begin
            tick(1);
            n++;
            if (n > lim) begin
                fails++;
                complete_run();
            end
        end
    endtask : await
    task automatic wr(input int r, input logic [7:0] d);
        reg_wdata = d;
        {stab_time_select_wr, int_osc_mode_wr, x1_osc_control_wr, main_clock_mode_wr} = 4'h1 << r;
        tick(1);
        {stab_time_select_wr, int_osc_mode_wr, x1_osc_control_wr, main_clock_mode_wr} = 4'h0;
        tick(1);
        rnd = lfsr(rnd);
    endtask : wr
    task automatic pulse(input int p);
        {wake, stop_req, halt_req} = 3'h1 << p;
        tick(1);
        {wake, stop_req, halt_req} = 3'h0;
    endtask : pulse
    // counts cpu, peripheral and watchdog enables over c cycles
    task automatic count(input int c);
        {n, k, m} = '0;
        repeat (c) begin
            tick(1);
            n += cpu_clk_en;
            k += periph_clk_en;
            m += watchdog_clk_en;
        end
    endtask : count
    // main sequence
    initial begin
        {rst_n, ext_reset_n, power_on_clear, low_voltage_detect, watchdog_reset} = 5'h0;
        {stab_time_select_wr, int_osc_mode_wr, x1_osc_control_wr, main_clock_mode_wr} = 4'h0;
        {wake, stop_req, halt_req} = 3'h0;
        {reg_wdata, rnd, int_osc_stoppable_opt} = {8'h00, 8'h55, 1'h1};
        {fails, samples_checked, ie} = '0;
        tick(16);
        chk(main_clock_mode_reg, 8'h00);
        chk(stab_time_select_reg, 8'h05);
        chk({x1_osc_enable, int_osc_enable}, 2'h0);
        rst_n = 1'h1;
        tick(3);
        ie = 0; // oscillator stands still in reset, so no edge is missed
        ext_reset_n = 1'h1;
        await(3, 1'h0, 100);
        await(0, 1'h1, 2000);
        chk(ie, 18);
        $display("start done");
        await(2, 1'h1, 20000);
        chk(stab_count_status_reg, 8'h10);
        count(240);
        chk(k inside {[11:13]}, 1'h1);
        // write just after an x1 rise so the switch cannot complete before the check
        await(4, 1'h0, 20);
        await(4, 1'h1, 20);
        wr(0, {rnd[7:1], 1'h1});
        chk(main_clock_mode_reg[1:0], 2'h1);
        await(1, 1'h1, 100);
        chk(main_clock_mode_reg[1:0], 2'h3);
        count(240);
        chk(k inside {[39:41]}, 1'h1);
        wr(1, rnd | 8'h80);
        chk(x1_osc_control_reg, 8'h80);
        tick(20);
        chk(x1_osc_enable, 1'h1);
        wr(1, 8'h00);
        wr(2, 8'h01);
        chk(int_osc_mode_reg, 8'h01);
        tick(30);
        chk(int_osc_enable, 1'h0);
        wr(2, 8'h00);
        pulse(0);
        tick(1); // a watchdog pulse may still leave in the cycle halt is taken
        count(240);
        chk(n, 0);
        chk(m, 0);
        chk(k inside {[39:41]}, 1'h1);
        pulse(2);
        $display("x1 run and halt done");
        wr(3, 8'h01);
        chk(stab_time_select_reg, 8'h01);
        pulse(1);
        tick(30);
        pulse(2);
        await(0, 1'h1, 20000);
        chk(n > 12200, 1'h1);
        chk(main_clock_mode_reg[1], 1'h1);
        chk(stab_count_status_reg, 8'h10);
        wr(0, 8'h00);
        await(1, 1'h0, 100);
        pulse(1);
        tick(30);
        pulse(2);
        await(0, 1'h1, 60);
        chk(main_clock_mode_reg[1], 1'h0);
        wr(1, 8'h80);
        tick(30);
        chk(x1_osc_enable, 1'h0);
        wr(1, 8'h00);
        $display("stop release done");
        for (int s = 0; s < 4; s++) begin
            int_osc_stoppable_opt = (s != 3);
            {power_on_clear, low_voltage_detect, watchdog_reset, ext_reset_n} = 4'h1 ^ (4'h8 >> s);
            await(3, 1'h1, 10);
            tick(3);
            chk({main_clock_mode_reg[0], x1_osc_enable, int_osc_enable}, 3'h0);
            {power_on_clear, low_voltage_detect, watchdog_reset, ext_reset_n} = 4'h1;
            await(3, 1'h0, 10);
            await(0, 1'h1, 2000);
        end
        pulse(1);
        count(200);
        chk(n, 0);
        chk(m > 0, 1'h1);
        chk(watchdog_run, 1'h1);
        pulse(2);
        await(0, 1'h1, 60);
        $display("reset sources done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
